// ---- aux_timer.sv ----
// Auxiliary 8-bit timer with prescaler, period and one PWM channel.
`timescale 1ns/10ps
module aux_timer (
  // Clock and reset.
  input  wire logic                            sys_clk,
  input  wire logic                            sys_rst,
  // Configuration.
  input  wire timer_pkg::count_mode_t          mode,
  input  wire logic [timer_pkg::PRESC_W-1:0]   presc,
  input  wire logic [timer_pkg::AUX_W-1:0]     period,
  input  wire logic [timer_pkg::AUX_W-1:0]     compare,
  input  wire logic                            pwm_init,
  // Event pulse, already synchronous.
  input  wire logic                            event_pulse,
  // Status and output.
  output logic [timer_pkg::AUX_W-1:0]          count,
  output logic                                 wrap,
  output logic                                 pwm_out
);
  import timer_pkg::*;
  logic [PRESC_W-1:0] presc_cnt;
  wire presc_tick = (presc_cnt >= presc);
  wire step       = (mode == MODE_TIMER) ? presc_tick :
                    (mode == MODE_EVENT) ? event_pulse : 1'b0;
  wire at_period  = (count == period);
  wire [AUX_W-1:0] next_count = at_period ? AUX_RESET : AUX_W'(count + 1'b1);
  wire hit        = step && (next_count == compare);

  always_ff @(posedge sys_clk) begin
    if (sys_rst || mode == MODE_STOP || presc_tick) begin
      presc_cnt <= PRESC_RESET;
    end else begin
      presc_cnt <= PRESC_W'(presc_cnt + 1'b1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      count   <= AUX_RESET;
      wrap    <= 1'b0;
      pwm_out <= 1'b0;
    end else begin
      wrap <= step && at_period;
      if (step) begin
        count <= next_count;
        if (at_period && compare != AUX_RESET) begin
          pwm_out <= pwm_init;
        end else if (hit) begin
          pwm_out <= ~pwm_init;
        end
      end
    end
  end
endmodule // aux_timer

// ---- main_timer.sv ----
// Main 16-bit timer with five compare or capture channels and IR modulation.
`timescale 1ns/10ps
module main_timer (
  // Clock and reset.
  input  wire logic                                   sys_clk,
  input  wire logic                                   sys_rst,
  // Main timer configuration.
  input  wire timer_pkg::count_mode_t                 mode,
  input  wire logic [timer_pkg::PRESC_W-1:0]          presc,
  input  wire logic [timer_pkg::MAIN_W-1:0]           period,
  input  wire logic                                   consumer_ir_modulation_mode,
  // Channel configuration, one bit or word per channel.
  input  wire logic [timer_pkg::NUM_CH-1:0]           ch_capture,
  input  wire logic [timer_pkg::NUM_CH*2-1:0]         ch_edge,
  input  wire logic [timer_pkg::NUM_CH-1:0]           ch_pwm_init,
  input  wire logic [timer_pkg::NUM_CH*16-1:0]        ch_compare,
  // Auxiliary timer configuration.
  input  wire timer_pkg::count_mode_t                 aux_mode,
  input  wire logic [timer_pkg::PRESC_W-1:0]          aux_presc,
  input  wire logic [timer_pkg::AUX_W-1:0]            aux_period,
  input  wire logic [timer_pkg::AUX_W-1:0]            aux_compare,
  input  wire logic                                   aux_pwm_init,
  // Pins.
  input  wire logic                                   event_pin,
  input  wire logic                                   aux_event_pin,
  input  wire logic [timer_pkg::NUM_CH-1:0]           capture_pin,
  output logic      [timer_pkg::NUM_CH-1:0]           pwm_pin,
  output logic                                        aux_pwm_pin,
  output logic                                        ir_out,
  // Status.
  output logic      [timer_pkg::MAIN_W-1:0]           count,
  output logic      [timer_pkg::AUX_W-1:0]            aux_count,
  output logic      [timer_pkg::NUM_CH*16-1:0]        ch_captured,
  output logic      [timer_pkg::NUM_CH-1:0]           ch_capture_flag,
  input  wire logic [timer_pkg::NUM_CH-1:0]           ch_flag_clear
);
  import timer_pkg::*;

  // Two-stage synchronisers for every pin input.
  logic [NUM_CH+1:0] sync_a;
  logic [NUM_CH+1:0] sync_b;
  logic [NUM_CH+1:0] sync_prev;
  wire  [NUM_CH+1:0] pins = {aux_event_pin, event_pin, capture_pin};

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sync_a    <= '0;
      sync_b    <= '0;
      sync_prev <= '0;
    end else begin
      sync_a    <= pins;
      sync_b    <= sync_a;
      sync_prev <= sync_b;
    end
  end

  wire [NUM_CH+1:0] rise = sync_b & ~sync_prev;
  wire [NUM_CH+1:0] fall = ~sync_b & sync_prev;

  // Auxiliary timer.
  logic aux_wrap;
  logic aux_pwm;

  aux_timer i_aux_timer (
    .sys_clk     (sys_clk),
    .sys_rst     (sys_rst),
    .mode        (aux_mode),
    .presc       (aux_presc),
    .period      (aux_period),
    .compare     (aux_compare),
    .pwm_init    (aux_pwm_init),
    .event_pulse (rise[NUM_CH+1]),
    .count       (aux_count),
    .wrap        (aux_wrap),
    .pwm_out     (aux_pwm)
  );

  // Prescaler for the main timer.
  logic [PRESC_W-1:0] presc_cnt;
  // A lowered divider must not leave the prescaler running through its whole range.
  wire presc_tick = (presc_cnt >= presc);

  always_ff @(posedge sys_clk) begin
    if (sys_rst || mode == MODE_STOP || presc_tick) begin
      presc_cnt <= PRESC_RESET;
    end else begin
      presc_cnt <= PRESC_W'(presc_cnt + 1'b1);
    end
  end

  // In IR mode one step is one completed auxiliary period.
  wire base_step = (mode == MODE_TIMER) ? presc_tick :
                   (mode == MODE_EVENT) ? rise[NUM_CH] : 1'b0;
  wire step      = (mode == MODE_STOP) ? 1'b0 :
                   consumer_ir_modulation_mode ? aux_wrap : base_step;
  wire at_period = (count == period);
  wire [MAIN_W-1:0] next_count = at_period ? MAIN_RESET : MAIN_W'(count + 1'b1);

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      count <= MAIN_RESET;
    end else if (step) begin
      count <= next_count;
    end
  end

  function automatic logic edge_match(input logic [1:0] sel, input logic r, input logic f);
    edge_match = ((sel == EDGE_RISE) && r) || ((sel == EDGE_FALL) && f) ||
                 ((sel == EDGE_BOTH) && (r || f));
  endfunction

  // Channels.
  logic [NUM_CH-1:0] ch_pwm;

  genvar i;
  generate
    for (i = 0; i < NUM_CH; i++) begin : g_ch
      wire [MAIN_W-1:0] cmp = ch_compare[i*16 +: 16];
      wire hit = step && (next_count == cmp);
      wire cap = ch_capture[i] && edge_match(ch_edge[i*2 +: 2], rise[i], fall[i]);

      always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
          ch_pwm[i]                <= 1'b0;
          ch_captured[i*16 +: 16]  <= MAIN_RESET;
          ch_capture_flag[i]       <= 1'b0;
        end else begin
          if (cap) begin
            ch_captured[i*16 +: 16] <= count;
          end
          // A new capture wins over a simultaneous clear.
          ch_capture_flag[i] <= cap | (ch_capture_flag[i] & ~ch_flag_clear[i]);
          if (ch_capture[i]) begin
            ch_pwm[i] <= ch_pwm_init[i];
          end else if (step && at_period && cmp != MAIN_RESET) begin
            ch_pwm[i] <= ch_pwm_init[i];
          end else if (hit) begin
            ch_pwm[i] <= ~ch_pwm_init[i];
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pwm_pin     <= '0;
      aux_pwm_pin <= 1'b0;
      ir_out      <= 1'b0;
    end else begin
      pwm_pin     <= ch_pwm & ~ch_capture;
      aux_pwm_pin <= aux_pwm;
      ir_out      <= consumer_ir_modulation_mode ? (ch_pwm[0] & aux_pwm) : ch_pwm[0];
    end
  end
endmodule // main_timer

// ---- pwm_capture_timers_ir_mod_bench.sv ----
// Testbench for the dual timer block.
`timescale 1ns/10ps
module pwm_capture_timers_ir_mod_bench;
  import timer_pkg::*;
  logic sys_clk = 0, sys_rst = 1, irm = 0, aux_pwm_init = 0;
  count_mode_t mode = MODE_TIMER, aux_mode = MODE_TIMER;
  logic [7:0]  presc = 8'h00, aux_presc = 8'h00, aux_period = 8'h03, aux_compare = 8'h01, a0;
  logic [15:0] period = 16'h0003, c0;
  logic [4:0]  ch_capture = 0, ch_pwm_init = 0, ch_flag_clear = 0;
  logic [9:0]  ch_edge = 10'h004;
  logic [79:0] ch_compare = 80'h2;
  logic [6:0]  req = 0;
  wire  [6:0]  pins;
  wire  [4:0]  pwm_pin, ch_capture_flag;
  wire         aux_pwm_pin, ir_out;
  wire  [15:0] count;
  wire  [7:0]  aux_count;
  wire  [79:0] ch_captured;
  int          n_mismatch = 0, n_checks = 0, i;
  always #50 sys_clk = ~sys_clk;
  timer_pins i_timer_pins (.sys_clk(sys_clk), .req(req), .pins(pins));
  main_timer i_main_timer (.sys_clk(sys_clk), .sys_rst(sys_rst), .mode(mode), .presc(presc),
    .period(period), .consumer_ir_modulation_mode(irm), .ch_capture(ch_capture),
    .ch_edge(ch_edge), .ch_pwm_init(ch_pwm_init), .ch_compare(ch_compare),
    .aux_mode(aux_mode), .aux_presc(aux_presc), .aux_period(aux_period),
    .aux_compare(aux_compare), .aux_pwm_init(aux_pwm_init), .event_pin(pins[5]),
    .aux_event_pin(pins[6]), .capture_pin(pins[4:0]), .pwm_pin(pwm_pin),
    .aux_pwm_pin(aux_pwm_pin), .ir_out(ir_out), .count(count), .aux_count(aux_count),
    .ch_captured(ch_captured), .ch_capture_flag(ch_capture_flag),
    .ch_flag_clear(ch_flag_clear));
  task tick; @(posedge sys_clk); #1; endtask
  task end_of_test;
    $display("mismatches %0d checks %0d", n_mismatch, n_checks);
    if (n_mismatch == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      n_mismatch++;
    end
  endtask
  function logic [15:0] probe(input int s);
    case (s)
      0: return count;
      1: return {8'h00, aux_count};
      2: return {11'h000, ch_capture_flag};
      default: return {15'h0000, ir_out};
    endcase
  endfunction
  // Waits, with a bound, until the probed output shows the value.
  task wt(input int s, input logic [15:0] v);
    for (i = 0; probe(s) !== v; i++) begin
      if (i == 200) begin
        n_mismatch++;
        end_of_test;
      end
      tick;
    end
  endtask
  initial begin
    repeat (5) tick;
    sys_rst = 0;
    chk(count, 16'h0000);
    wt(0, 16'h0003); tick; chk(count, 16'h0000);
    wt(0, 16'h0003); chk(pwm_pin, 16'h001F);
    wt(0, 16'h0001); chk(pwm_pin, 16'h001E);
    wt(1, 16'h0003); tick; chk(aux_count, 16'h0000);
    wt(1, 16'h0002); chk(aux_pwm_pin, 16'h0001);
    wt(1, 16'h0001); chk(aux_pwm_pin, 16'h0000);
    presc = 8'h01; period = 16'h00FF; tick; c0 = count; repeat (2) tick;
    chk(count, c0 + 16'h0001);
    presc = 8'h00; period = 16'hFFFF; ch_capture = 5'h02; ch_edge = 10'h00C; tick;
    req = 7'h02; tick; req = 0;
    wt(2, 16'h0002); chk(ch_captured[31:16], count - 16'h0001);
    chk(pwm_pin[1], 16'h0000);
    ch_flag_clear = 5'h02; tick; ch_flag_clear = 0; tick;
    chk(ch_capture_flag, 16'h0000);
    ch_edge = 10'h008; req = 7'h02; tick; req = 7'h00;
    wt(2, 16'h0002); chk(ch_captured[31:16], count - 16'h0001);
    mode = MODE_EVENT; aux_mode = MODE_EVENT; repeat (4) tick; c0 = count; a0 = aux_count;
    repeat (6) begin
      req = 7'h60; tick; req = 0; repeat (3) tick;
    end
    repeat (4) tick; chk(count, c0 + 16'h0003);
    chk(aux_count, {8'h00, (a0 + 8'h03) & 8'h03});
    mode = MODE_STOP; aux_mode = MODE_STOP; tick; c0 = count; a0 = aux_count; repeat (5) tick;
    chk(count, c0);
    chk(aux_count, {8'h00, a0});
    mode = MODE_TIMER; aux_mode = MODE_TIMER; period = 3; irm = 1;
    sys_rst = 1; tick; sys_rst = 0;
    repeat (10) tick; c0 = count; repeat (8) tick;
    chk(count, (c0 + 16'h0002) & 16'h0003);
    wt(3, 16'h0000); wt(3, 16'h0001); chk(count[1], 16'h0001);
    repeat (3) tick; chk({pwm_pin[0], ir_out}, 16'h0002);
    end_of_test;
  end
endmodule // pwm_capture_timers_ir_mod_bench
bind main_timer timer_chk i_timer_chk (.sys_clk(sys_clk), .sys_rst(sys_rst), .mode(mode),
  .period(period), .consumer_ir_modulation_mode(consumer_ir_modulation_mode),
  .ch_capture(ch_capture), .aux_period(aux_period), .count(count),
  .aux_count(aux_count), .pwm_pin(pwm_pin), .aux_pwm_pin(aux_pwm_pin), .ir_out(ir_out));

// ---- timer_chk.sv ----
// Checker for the dual timer's counting and output relations.
`timescale 1ns/10ps
module timer_chk (
  // Clock and reset.
  input wire logic                  sys_clk,
  input wire logic                  sys_rst,
  // Watched ports.
  input wire timer_pkg::count_mode_t mode,
  input wire logic [15:0]           period,
  input wire logic                  consumer_ir_modulation_mode,
  input wire logic [4:0]            ch_capture,
  input wire logic [7:0]            aux_period,
  input wire logic [15:0]           count,
  input wire logic [7:0]            aux_count,
  input wire logic [4:0]            pwm_pin,
  input wire logic                  aux_pwm_pin,
  input wire logic                  ir_out
);
  import timer_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  sequence s_top;
    $past(count) == $past(period) && count != $past(count);
  endsequence
  sequence s_aux_top;
    $past(aux_count) == $past(aux_period) && aux_count != $past(aux_count);
  endsequence
  AST_MAIN_STEP:
    assert property (count != $past(count) |-> count == $past(count) + 16'h0001
      || count == 16'h0000) else $error("main count jumped");
  AST_MAIN_WRAP:
    assert property (s_top |-> count == 16'h0000) else $error("main count did not wrap");
  AST_STOP_HOLD:
    assert property ($past(mode) == MODE_STOP |-> $stable(count)) else $error("stop moved");
  AST_AUX_STEP:
    assert property (aux_count != $past(aux_count) |-> aux_count == $past(aux_count)
      + 8'h01 || aux_count == 8'h00) else $error("aux count jumped");
  AST_AUX_WRAP:
    assert property (s_aux_top |-> aux_count == 8'h00) else $error("aux did not wrap");
  AST_CAP_QUIET:
    assert property ((pwm_pin & $past(ch_capture) & $past(ch_capture, 2)) == 5'h00)
      else $error("capture channel drives pwm");
  AST_IR_PLAIN:
    assert property (!$past(consumer_ir_modulation_mode) && !$past(ch_capture[0])
      |-> ir_out == pwm_pin[0]) else $error("ir out differs from channel 0");
  AST_IR_AND:
    assert property ($past(consumer_ir_modulation_mode) && !$past(ch_capture[0])
      |-> ir_out == (pwm_pin[0] & aux_pwm_pin)) else $error("ir out is not the and");
  AST_IR_STEP:
    assert property (consumer_ir_modulation_mode && $past(consumer_ir_modulation_mode, 3)
      && count != $past(count) |-> $past(aux_count) == 8'h00 ||
      $past(aux_count, 2) == 8'h00 || $past(aux_count, 3) == 8'h00)
      else $error("ir step without aux wrap");
endmodule // timer_chk

// ---- timer_pins.sv ----
// Model of the external pins: toggles a pin for each request bit.
`timescale 1ns/10ps
module timer_pins (
  // Clock and requests.
  input wire logic       sys_clk,
  input wire logic [6:0] req,
  // Pin levels: capture pins, event pin, aux event pin.
  output logic     [6:0] pins
);
  initial pins = 7'h00;
  always @(posedge sys_clk) begin
    pins <= #1 pins ^ req;
  end
endmodule // timer_pins

// ---- timer_pkg.sv ----
// Constants and types shared by the dual timer block.
package timer_pkg;
  localparam int MAIN_W      = 16;
  localparam int AUX_W       = 8;
  localparam int NUM_CH      = 5;
  localparam int PRESC_W     = 8;
  localparam logic [MAIN_W-1:0] MAIN_RESET = 16'h0000;
  localparam logic [AUX_W-1:0]  AUX_RESET  = 8'h00;
  localparam logic [PRESC_W-1:0] PRESC_RESET = 8'h00;
  // Capture edge selection codes.
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  typedef enum logic [1:0] {
    MODE_STOP  = 2'h0,
    MODE_TIMER = 2'h1,
    MODE_EVENT = 2'h3
  } count_mode_t;
endpackage
